// ### src/tcis_pkg.sv
// Shared constants and types for the touch controller host link.
// Assumes a 100 MHz core clock; every user of the constants imports this package.
package tcis_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_KHZ        = 100_000;
  localparam int unsigned READY_MAX_MS        = 200;
  // A longest time rounds down, so the figure is exact here
  localparam int unsigned READY_CYCLES        = READY_MAX_MS * CORE_CLK_KHZ;
  localparam int unsigned RDY_CNT_W           = 25;
  // Host obligations, kept for reference; the bench does not use them
  localparam int unsigned HOST_SCL_MAX_KHZ    = 400;
  localparam int unsigned HOST_PRE_PWR_RST_US = 100;
  localparam int unsigned HOST_RST_LOW_MS     = 1;

  // ----------------------------------------------------------------
  // Link framing
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned BYTE_W    = 8;
  // Target address; the value is arbitrary
  localparam logic [6:0]  OWN_ADDR  = 7'h2a;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic        RW_READ   = 1'b1;
  localparam logic [7:0]  IDLE_FILL = 8'hff;

  typedef enum logic [2:0] {
    TCIS_IDLE     = 3'b000,
    TCIS_ADDR     = 3'b001,
    TCIS_ADDR_ACK = 3'b010,
    TCIS_WRITE    = 3'b011,
    TCIS_WR_ACK   = 3'b100,
    TCIS_READ     = 3'b101,
    TCIS_RD_ACK   = 3'b110
  } tcis_state_t;

endpackage

// ### src/tcis_sync.sv
// Two flip-flop synchroniser for a group of independent levels or toggles.
// Assumes each bit changes at most once per several destination clocks.
`timescale 1ns/1ns
`default_nettype none
module tcis_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Two stages; the first is read by the second only
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ### src/tcis_touch_i2c.sv
// Touch controller host link: I2C target engine and start-up sequencing.
// Assumes scl and sda arrive raw from pins and link_clk oversamples them well above SCL.
//
// What this block does
// - The block is a target only and never drives the serial clock.
// - Every start or repeated start is followed by a seven bit address, MSB first, fully decoded.
// - The bit after the address selects read when high and write when low.
// - A repeated start without a stop closes the open packet and opens the next.
// - Touch reporting is ready no later than 200 ms after reset release.
`timescale 1ns/1ns
`default_nettype none
module tcis_touch_i2c
#(
  parameter int unsigned READY_DLY = tcis_pkg::READY_CYCLES
) (
  // Core clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // Link clock oversampling the bus
  input  wire logic                      link_clk,
  // I2C pins; scl is input only
  input  wire logic                      scl,
  input  wire logic                      sda,
  output logic                           sda_o,
  output logic                           sda_oe,
  // Start-up status
  output logic                           report_ready,
  // Packet events, core domain
  output logic                           pkt_start,
  output logic                           pkt_read,
  output logic                           pkt_end,
  // Received data, core domain
  output logic                           rx_valid,
  output logic [tcis_pkg::BYTE_W-1:0]    rx_data,
  // Data to send, core domain
  input  wire logic [tcis_pkg::BYTE_W-1:0] tx_data,
  output logic                           tx_pop
);
  import tcis_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 lrst_n;
  logic [1:0]           pin_s;
  logic                 scl_s, sda_s, scl_p_q, sda_p_q;
  logic                 scl_rise, scl_fall, start_det, stop_det;
  logic                 ready_l, tx_ack_l;
  tcis_state_t          state_q;
  logic [2:0]           bit_q;
  logic [BYTE_W-1:0]    shift_q, rx_byte_q;
  logic                 got8_q, sda_oe_q, rw_q, in_pkt_q;
  logic                 rx_tog_q, start_tog_q, end_tog_q, tx_req_q;
  logic [RDY_CNT_W-1:0] rdy_cnt_q;
  logic                 ready_q, tx_ack_q;
  logic [BYTE_W-1:0]    tx_hold_q, rx_data_q;
  logic [BYTE_W-1:0]    next_byte;
  logic [3:0]           fwd_s, fwd_p_q, fwd_edge;
  logic                 rx_valid_q, pkt_start_q, pkt_end_q, pkt_read_q, tx_pop_q;

  // Byte to put on the wire; a byte not yet delivered by the core reads as fill
  function automatic logic [BYTE_W-1:0] tcis_next_byte(input logic req, input logic ack,
                                                       input logic [BYTE_W-1:0] hold);
    tcis_next_byte = (req != ack) ? IDLE_FILL : hold;
  endfunction
  assign next_byte = tcis_next_byte(tx_req_q, tx_ack_l, tx_hold_q);

  // ----------------------------------------------------------------
  // Link domain reset and pin sampling
  // ----------------------------------------------------------------
  // Reset asserts at once and releases on the link clock
  tcis_sync #(.W(1)) u_lrst (.clk(link_clk), .rst_n(rst_n), .d(1'b1), .q(lrst_n));

  tcis_sync #(.W(2)) u_pins (.clk(link_clk), .rst_n(lrst_n), .d({scl, sda}), .q(pin_s));

  // Status coming back from the core
  tcis_sync #(.W(2)) u_back (.clk(link_clk), .rst_n(lrst_n), .d({ready_q, tx_ack_q}),
                             .q({ready_l, tx_ack_l}));

  assign {scl_s, sda_s} = pin_s;

  // Previous sample for edge and condition detection
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Start and stop are SDA moves while SCL stays high
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ----------------------------------------------------------------
  // Target state machine
  // ----------------------------------------------------------------
  // SDA is only changed after a sampled SCL fall, so our own drive
  // can never look like a start or stop to us.
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      state_q     <= TCIS_IDLE;
      bit_q       <= 3'h0;
      shift_q     <= 8'h00;
      got8_q      <= 1'b0;
      sda_oe_q    <= 1'b0;
      rw_q        <= 1'b0;
      in_pkt_q    <= 1'b0;
      rx_byte_q   <= 8'h00;
      rx_tog_q    <= 1'b0;
      start_tog_q <= 1'b0;
      end_tog_q   <= 1'b0;
      tx_req_q    <= 1'b0;
    end else if (start_det || stop_det) begin
      // Close the open packet on stop or repeated start
      if (in_pkt_q) begin
        end_tog_q <= ~end_tog_q;
      end
      in_pkt_q <= 1'b0;
      sda_oe_q <= 1'b0;
      bit_q    <= 3'h0;
      got8_q   <= 1'b0;
      state_q  <= start_det ? TCIS_ADDR : TCIS_IDLE;
    end else begin
      case (state_q)
        TCIS_ADDR, TCIS_WRITE: begin
          if (scl_rise) begin
            shift_q <= {shift_q[BYTE_W-2:0], sda_s};
            bit_q   <= bit_q + 3'h1;
            got8_q  <= (bit_q == LAST_BIT);
          end else if (scl_fall && got8_q) begin
            got8_q <= 1'b0;
            if (state_q == TCIS_WRITE) begin
              sda_oe_q  <= 1'b1;
              rx_byte_q <= shift_q;
              rx_tog_q  <= ~rx_tog_q;
              state_q   <= TCIS_WR_ACK;
            end else if (shift_q[BYTE_W-1:1] == OWN_ADDR && ready_l) begin
              // Whole address must match before we pull SDA low
              sda_oe_q    <= 1'b1;
              rw_q        <= shift_q[0];
              in_pkt_q    <= 1'b1;
              start_tog_q <= ~start_tog_q;
              if (shift_q[0] == RW_READ) begin
                tx_req_q <= ~tx_req_q;
              end
              state_q <= TCIS_ADDR_ACK;
            end else begin
              state_q <= TCIS_IDLE;
            end
          end
        end
        TCIS_ADDR_ACK: begin
          if (scl_fall) begin
            bit_q <= 3'h0;
            if (rw_q == RW_READ) begin
              shift_q  <= next_byte;
              sda_oe_q <= ~next_byte[BYTE_W-1];
              state_q  <= TCIS_READ;
            end else begin
              sda_oe_q <= 1'b0;
              state_q  <= TCIS_WRITE;
            end
          end
        end
        TCIS_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            bit_q    <= 3'h0;
            state_q  <= TCIS_WRITE;
          end
        end
        TCIS_READ: begin
          if (scl_fall) begin
            if (bit_q == LAST_BIT) begin
              sda_oe_q <= 1'b0;
              state_q  <= TCIS_RD_ACK;
            end else begin
              shift_q  <= {shift_q[BYTE_W-2:0], 1'b0};
              sda_oe_q <= ~shift_q[BYTE_W-2];
              bit_q    <= bit_q + 3'h1;
            end
          end
        end
        TCIS_RD_ACK: begin
          if (scl_rise) begin
            // Host acknowledge asks for another byte
            got8_q <= ~sda_s;
            if (!sda_s) begin
              tx_req_q <= ~tx_req_q;
            end
          end else if (scl_fall) begin
            got8_q <= 1'b0;
            bit_q  <= 3'h0;
            if (got8_q) begin
              shift_q  <= next_byte;
              sda_oe_q <= ~next_byte[BYTE_W-1];
              state_q  <= TCIS_READ;
            end else begin
              state_q <= TCIS_IDLE;
            end
          end
        end
        default: begin
          state_q <= TCIS_IDLE;
        end
      endcase
    end
  end

  // Open drain: only ever pull low; SCL has no driver at all
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  // ----------------------------------------------------------------
  // Core domain: start-up timer
  // ----------------------------------------------------------------
  // Ready rises at READY_DLY cycles after release, inside the bound
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_cnt_q <= '0;
      ready_q   <= 1'b0;
    end else if (!ready_q) begin
      if (rdy_cnt_q == RDY_CNT_W'(READY_DLY - 1)) begin
        ready_q <= 1'b1;
      end else begin
        rdy_cnt_q <= rdy_cnt_q + RDY_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: events and data from the link
  // ----------------------------------------------------------------
  tcis_sync #(.W(4)) u_fwd (.clk(core_clk), .rst_n(rst_n),
                            .d({rx_tog_q, start_tog_q, end_tog_q, tx_req_q}), .q(fwd_s));

  assign fwd_edge = fwd_s ^ fwd_p_q;

  // Link data registers are stable while their toggle settles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_p_q     <= 4'h0;
      rx_valid_q  <= 1'b0;
      rx_data_q   <= 8'h00;
      pkt_start_q <= 1'b0;
      pkt_read_q  <= 1'b0;
      pkt_end_q   <= 1'b0;
    end else begin
      fwd_p_q     <= fwd_s;
      rx_valid_q  <= fwd_edge[3];
      pkt_start_q <= fwd_edge[2];
      pkt_end_q   <= fwd_edge[1];
      if (fwd_edge[3]) begin
        rx_data_q <= rx_byte_q;
      end
      if (fwd_edge[2]) begin
        pkt_read_q <= rw_q;
      end
    end
  end

  // Capture the next transmit byte and hand it back by toggle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_q <= 8'h00;
      tx_ack_q  <= 1'b0;
      tx_pop_q  <= 1'b0;
    end else begin
      tx_pop_q <= fwd_edge[0];
      if (fwd_edge[0]) begin
        tx_hold_q <= tx_data;
        tx_ack_q  <= ~tx_ack_q;
      end
    end
  end

  assign report_ready = ready_q;
  assign pkt_start    = pkt_start_q;
  assign pkt_read     = pkt_read_q;
  assign pkt_end      = pkt_end_q;
  assign rx_valid     = rx_valid_q;
  assign rx_data      = rx_data_q;
  assign tx_pop       = tx_pop_q;

endmodule
`default_nettype wire

// ### dv/tcis_props.sv
// Port checker for the touch host link target.
// Assumes a bind onto tcis_touch_i2c; both clocks share rst_n.
`timescale 1ns/1ns
`default_nettype none
module tcis_props #(
  parameter int unsigned READY_DLY = 50
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // Bus side
  input wire logic scl,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Core side
  input wire logic report_ready,
  input wire logic pkt_start,
  input wire logic pkt_read,
  input wire logic pkt_end,
  input wire logic rx_valid,
  input wire logic tx_pop
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  int unsigned cyc_q;
  logic        open_q;
  // Cycles since release, frozen once reporting starts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= 0;
    end else if (!report_ready) begin
      cyc_q <= cyc_q + 1;
    end
  end
  // Packet open between start and end pulses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_q <= 1'b0;
    end else if (pkt_start || pkt_end) begin
      open_q <= pkt_start;
    end
  end
  sequence s_once(sig);
    sig ##1 !sig;
  endsequence
  sda_edge_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    $changed(sda_oe) |-> !scl && !$past(scl)) else $error("sda moved under high scl");
  open_drain_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    sda_oe |-> !sda_o) else $error("sda driven high");
  ready_gate_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    !report_ready |-> !sda_oe) else $error("ack before ready");
  ready_late_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !report_ready |-> cyc_q <= READY_DLY + 1) else $error("ready too late");
  ready_early_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(report_ready) |-> cyc_q + 1 >= READY_DLY) else $error("ready too early");
  start_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pkt_start |-> report_ready && !open_q ##0 s_once(pkt_start)) else $error("bad start");
  end_open_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pkt_end |-> open_q) else $error("end without packet");
  read_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(pkt_read) |-> pkt_start) else $error("direction moved alone");
  rx_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_valid |-> open_q && !pkt_read) else $error("byte outside write");
  tx_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tx_pop |-> pkt_read && (open_q || pkt_start)) else $error("fetch outside read");
endmodule
bind tcis_touch_i2c tcis_props #(.READY_DLY(READY_DLY)) i_tcis_props (
  .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .scl(scl), .sda_o(sda_o),
  .sda_oe(sda_oe), .report_ready(report_ready), .pkt_start(pkt_start),
  .pkt_read(pkt_read), .pkt_end(pkt_end), .rx_valid(rx_valid), .tx_pop(tx_pop));
`default_nettype wire

// ### dv/tcis_host.sv
// Host master model for the touch link.
// Assumes a pull-up on sda; steps on falling core_clk edges.
`timescale 1ns/1ns
`default_nettype none
module tcis_host #(
  parameter int unsigned QTR = 63
) (
  // Step clock and resolved line
  input  wire logic core_clk,
  input  wire logic sda,
  // Host drives; sda_dn pulls the line low
  output logic      scl,
  output logic      sda_dn
);
  // ----------------------------------------------------------------
  // Bus steps
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
  end
  // One quarter bit; 4 x 630 ns keeps SCL under 400 kHz
  task automatic st(input logic c, input logic d);
    scl = c;
    sda_dn = d;
    repeat (QTR) @(negedge core_clk);
  endtask
  // Start or repeated start: SDA falls with SCL high
  task automatic start();
    st(scl, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
  endtask
  task automatic stop();
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
  endtask
  // Data set while SCL low, sampled mid high
  task automatic bit_x(input logic b, output logic r);
    st(1'b0, ~b);
    st(1'b1, ~b);
    r = sda;
    st(1'b1, ~b);
    st(1'b0, ~b);
  endtask
  // Byte MSB first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] r,
                      output logic nk);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(ack, nk);
  endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the touch host link target.
// Assumes tcis_host as bus master and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tcis_pkg::*;
  localparam int unsigned DLY = 3000;
  logic       core_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       scl;
  logic       sda_dn;
  logic       sda_o;
  logic       sda_oe;
  logic       report_ready;
  logic       pkt_start;
  logic       pkt_read;
  logic       pkt_end;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic [7:0] tx_data = 8'h96;
  logic       tx_pop;
  int         fail_count = 0;
  int         n_tests = 0;
  int         n_start = 0;
  int         n_end = 0;
  int         s0;
  int         e0;
  int         cyc = 0;
  int         ready_at = 0;
  logic [7:0] rx_q[$];
  // Open drain line with pull-up
  wire logic  sda_bus = !(sda_dn || (sda_oe && !sda_o));
  // ----------------------------------------------------------------
  // Clocks, parts, monitor
  // ----------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  initial begin
    #17;
    forever #40 link_clk = ~link_clk;
  end
  tcis_touch_i2c #(.READY_DLY(DLY)) i_tcis_touch_i2c (
    .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .scl(scl), .sda(sda_bus),
    .sda_o(sda_o), .sda_oe(sda_oe), .report_ready(report_ready), .pkt_start(pkt_start),
    .pkt_read(pkt_read), .pkt_end(pkt_end), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_data(tx_data), .tx_pop(tx_pop));
  tcis_host i_tcis_host (.core_clk(core_clk), .sda(sda_bus), .scl(scl), .sda_dn(sda_dn));
  // Sampled on falling edges so pulses are settled; tx_data steps after each fetch
  always @(negedge core_clk) begin
    cyc <= rst_n ? cyc + 1 : 0;
    if (report_ready === 1'b1 && ready_at == 0) begin
      ready_at <= cyc;
    end
    if (pkt_start === 1'b1) begin
      n_start <= n_start + 1;
    end
    if (pkt_end === 1'b1) begin
      n_end <= n_end + 1;
    end
    if (rx_valid === 1'b1) begin
      rx_q.push_back(rx_data);
    end
    if (tx_pop === 1'b1) begin
      tx_data <= ~tx_data;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: %h not %h", $time, msg, seen, exp);
    end
  endtask
  task automatic head(input logic [6:0] a, input logic rw, input logic nk_exp);
    logic [7:0] r;
    logic       nk;
    i_tcis_host.start();
    i_tcis_host.xfer({a, rw}, 1'b1, r, nk);
    check(8'(nk), 8'(nk_exp), "address ack");
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] r;
    logic       nk;
    i_tcis_host.xfer(d, 1'b1, r, nk);
    check(8'(nk), 8'h00, "write ack");
  endtask
  task automatic rd(input logic [7:0] exp, input logic last);
    logic [7:0] r;
    logic       nk;
    i_tcis_host.xfer(8'hff, last, r, nk);
    check(r, exp, "read byte");
    check(8'(nk), 8'(last), "line released");
  endtask
  // Stop, let pulses cross, compare packet counts since the last mark
  task automatic fin(input int ns, input int ne);
    i_tcis_host.stop();
    repeat (20) @(negedge core_clk);
    check(8'(n_start - s0), 8'(ns), "opened");
    check(8'(n_end - e0), 8'(ne), "closed");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    s0 = n_start;
    e0 = n_end;
    head(OWN_ADDR, 1'b0, 1'b1);
    fin(0, 0);
    for (int k = 0; k < DLY && report_ready !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    // One more edge so the monitor's capture of the ready time has landed
    @(negedge core_clk);
    check(8'(ready_at >= DLY - 1 && ready_at <= DLY + 2), 8'h01, "ready time");
    $display("boot done");
  endtask
  task automatic t_write();
    s0 = n_start;
    e0 = n_end;
    head(OWN_ADDR, 1'b0, 1'b0);
    wr(8'ha5);
    wr(8'h3c);
    fin(1, 1);
    check(8'(rx_q.size()), 8'h02, "count");
    check(rx_q[0], 8'ha5, "byte 0");
    check(rx_q[1], 8'h3c, "byte 1");
    check(8'(pkt_read), 8'h00, "write dir");
    $display("write done");
  endtask
  // Every single-bit miss of the own address, each tried once, direction alternating with the bit index
  task automatic t_wrong();
    s0 = n_start;
    e0 = n_end;
    for (int b = 0; b < 7; b++) begin
      head(OWN_ADDR ^ 7'(1 << b), 1'(b), 1'b1);
      fin(0, 0);
    end
    $display("wrong done");
  endtask
  task automatic t_read();
    s0 = n_start;
    e0 = n_end;
    head(OWN_ADDR, 1'b1, 1'b0);
    rd(8'h96, 1'b0);
    rd(8'h69, 1'b1);
    fin(1, 1);
    check(8'(pkt_read), 8'h01, "read dir");
    $display("read done");
  endtask
  task automatic t_restart();
    s0 = n_start;
    e0 = n_end;
    head(OWN_ADDR, 1'b0, 1'b0);
    wr(8'h11);
    head(OWN_ADDR, 1'b1, 1'b0);
    check(8'(n_end - e0), 8'h01, "restart close");
    rd(8'h96, 1'b1);
    fin(2, 2);
    check(rx_q[$], 8'h11, "last byte");
    $display("restart done");
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Host reset hold, shortened: the block needs only one link edge inside it
  initial begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    t_boot();
    t_write();
    t_wrong();
    t_read();
    t_restart();
    conclude();
  end
  // Run needs about 0.5 ms; twice that means a hang
  initial begin
    #1_000_000;
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
